// File: rtl/spi_core_pins.sv
// Master/slave SPI core: pin control, link-clock shifter, crossings, buffer
`default_nettype none
// How it works
// RL1 - As master, drive chip select 0 plus seven more, one per slave.
// RL2 - As slave, selection comes from the external chip-select input; no selects driven.
// RL3 - Serial clock driven when master, taken as input when slave.
// RL4 - Master-in line sampled when master, driven by the core when slave and selected.
// RL5 - Master-out line driven when master, received from the external master when slave.
// RL6 - Active-low flash select input routes an external access to the user flash.
// RL7 - Stand-by and wake-up stay low unless wake-up enable is configured.
// RL8 - One interrupt output in both modes, raised on transfer events.
module spi_core_pins #(
  parameter int DIV = 4,
  parameter bit WAKE_EN = 1'b0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_clk_link,
  input wire logic i_master_mode,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire spi_core_pkg::req_t i_tx_req,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output spi_core_pkg::req_t o_rx_word,
  output logic o_irq,
  input wire logic i_stby_req,
  input wire logic i_wake_req,
  output logic o_cfg_stby,
  output logic o_cfg_wake,
  output logic [spi_core_pkg::NUM_CS-1:0] o_csn,
  input wire logic i_scsn,
  input wire logic i_user_flash_select_n,
  input wire logic i_clk_pin,
  output logic o_clk_pin,
  output logic o_clk_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe
);
  import spi_core_pkg::*;

  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_LOW = 3'b010,
    M_HIGH = 3'b100
  } mst_t;

  typedef struct packed {
    mst_t st;
    logic [7:0] div;
    logic [CNT_W-1:0] bits;
    logic [DATA_W-1:0] sh;
    logic [DATA_W-1:0] rx;
    logic [NUM_CS-1:0] csn;
    logic sclk;
    logic done;
    logic [2:0] flash_sync;
    logic [1:0] tog_sync;
    logic tog_seen;
    logic irq;
    logic stby;
    logic wake;
    logic push;
    req_t push_word;
  } sys_t;

  typedef struct packed {
    logic [CNT_W-1:0] bits;
    logic [DATA_W-1:0] sh;
    logic [DATA_W-1:0] word;
    logic tog;
  } lnk_t;

  sys_t s_reg;
  sys_t s_next;
  lnk_t l_reg;
  lnk_t l_next;
  logic buf_ready;
  logic slave_sel;
  logic slave_toggle;

  if (DIV < 1 || DIV > 255)
  begin : g_div_check
    $error("DIV must lie in 1..255");
  end

  function automatic logic [NUM_CS-1:0] cs_decode(input logic [2:0] idx);
    cs_decode = ~(NUM_CS'(1) << idx);
  endfunction

  // Slave shifter runs on the external clock; it only shifts on edges inside a frame
  assign slave_sel = ~i_scsn | ~i_user_flash_select_n; // [RL2] [RL6]

  always_comb
  begin
    l_next = l_reg;
    if (slave_sel && !i_master_mode)
    begin
      l_next.sh = {l_reg.sh[DATA_W-2:0], i_mosi}; // [RL5]
      l_next.bits = l_reg.bits + 4'h1;
      if (l_reg.bits == BIT_LAST)
      begin
        l_next.word = {l_reg.sh[DATA_W-2:0], i_mosi};
        l_next.tog = ~l_reg.tog;
        l_next.bits = '0;
      end
    end
  end

  // Frame end cannot reset this domain, so the bit count is reset by select too
  // Reset must be released while the link is idle; its clock stands still then, so release is safe
  always_ff @(posedge i_clk_link or posedge i_rst)
  begin
    if (i_rst)
      l_reg <= '0;
    else if (!slave_sel)
    begin
      l_reg.bits <= '0;
      l_reg.sh <= l_reg.sh;
      l_reg.word <= l_reg.word;
      l_reg.tog <= l_reg.tog;
    end
    else
      l_reg <= l_next;
  end

  assign slave_toggle = s_reg.tog_sync[1] ^ s_reg.tog_seen;

  always_comb
  begin
    s_next = s_reg;
    s_next.flash_sync = {s_reg.flash_sync[1:0], ~i_user_flash_select_n};
    s_next.tog_sync = {s_reg.tog_sync[0], l_reg.tog};
    s_next.push = 1'b0;
    s_next.done = 1'b0;
    s_next.irq = 1'b0;
    s_next.stby = WAKE_EN & i_stby_req; // [RL7]
    s_next.wake = WAKE_EN & i_wake_req; // [RL7]
    if (s_reg.push && !buf_ready)
      s_next.push = 1'b1;
    else if (slave_toggle && !i_master_mode)
    begin
      s_next.tog_seen = s_reg.tog_sync[1];
      s_next.push = 1'b1;
      s_next.push_word.data = l_reg.word;
      s_next.push_word.cs_index = '0;
      s_next.push_word.flash = s_reg.flash_sync[2]; // [RL6]
      s_next.irq = 1'b1; // [RL8]
    end
    case (s_reg.st)
      M_IDLE:
      begin
        s_next.csn = CS_IDLE;
        s_next.sclk = 1'b0;
        if (i_master_mode && i_tx_valid && !s_reg.push)
        begin
          s_next.csn = cs_decode(i_tx_req.cs_index); // [RL1]
          s_next.sh = i_tx_req.data;
          s_next.bits = '0;
          s_next.div = '0;
          s_next.st = M_LOW;
        end
      end
      M_LOW:
      begin
        s_next.div = s_reg.div + 8'h1;
        if (s_reg.div == 8'(DIV - 1))
        begin
          s_next.div = '0;
          s_next.sclk = 1'b1;
          s_next.rx = {s_reg.rx[DATA_W-2:0], i_miso}; // [RL4]
          s_next.st = M_HIGH;
        end
      end
      M_HIGH:
      begin
        s_next.div = s_reg.div + 8'h1;
        if (s_reg.div == 8'(DIV - 1))
        begin
          s_next.div = '0;
          s_next.sclk = 1'b0;
          s_next.sh = {s_reg.sh[DATA_W-2:0], 1'b0};
          s_next.bits = s_reg.bits + 4'h1;
          if (s_reg.bits == BIT_LAST)
          begin
            s_next.st = M_IDLE;
            s_next.csn = CS_IDLE;
            s_next.done = 1'b1;
            s_next.irq = 1'b1; // [RL8]
            s_next.push = 1'b1;
            s_next.push_word.data = s_reg.rx;
            s_next.push_word.cs_index = '0;
            s_next.push_word.flash = 1'b0;
          end
          else
            s_next.st = M_LOW;
        end
      end
      default: s_next.st = M_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      s_reg <= '0;
      s_reg.st <= M_IDLE;
      s_reg.csn <= CS_IDLE;
    end
    else
      s_reg <= s_next;
  end

  spi_word_buffer #(
    .WIDTH($bits(req_t)),
    .DEPTH(2)
  ) u_rx_buf (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_valid(s_reg.push),
    .o_ready(buf_ready),
    .i_data(s_reg.push_word),
    .o_valid(o_rx_valid),
    .i_ready(i_rx_ready),
    .o_data(o_rx_word)
  );

  // A new master transfer waits until the previous word has a buffer slot
  assign o_tx_ready = i_master_mode && (s_reg.st == M_IDLE) && !s_reg.push;
  assign o_irq = s_reg.irq; // [RL8]
  assign o_cfg_stby = s_reg.stby;
  assign o_cfg_wake = s_reg.wake;
  assign o_csn = i_master_mode ? s_reg.csn : CS_IDLE; // [RL1] [RL2]
  assign o_clk_pin = s_reg.sclk;
  assign o_clk_oe = i_master_mode; // [RL3]
  assign o_mosi = s_reg.sh[DATA_W-1];
  assign o_mosi_oe = i_master_mode; // [RL5]
  assign o_miso = l_reg.sh[DATA_W-1];
  assign o_miso_oe = !i_master_mode && slave_sel; // [RL4]
endmodule
`default_nettype wire

// File: rtl/spi_core_pkg.sv
// Shared types and constants for the hardened SPI core pin block
`default_nettype none
package spi_core_pkg;
  localparam int NUM_CS = 8;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam logic [7:0] CS_IDLE = 8'hFF;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic valid;
  } word_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [2:0] cs_index;
    logic flash;
  } req_t;
endpackage
`default_nettype wire

// File: rtl/spi_word_buffer.sv
// Two-entry valid/ready buffer for received words
`default_nettype none
module spi_word_buffer #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  import spi_core_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [1:0] count;
  } buf_state_t;

  buf_state_t state_reg;
  buf_state_t state_next;
  logic push;
  logic pop;

  // The count width and the two-slot shuffle only serve a depth of two
  if (DEPTH != 2)
  begin : g_depth_check
    $error("spi_word_buffer supports DEPTH 2 only");
  end

  assign o_ready = (state_reg.count != FIFO_DEPTH);
  assign o_valid = (state_reg.count != 2'h0);
  assign o_data = state_reg.mem[0];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_comb
  begin
    state_next = state_reg;
    if (pop)
    begin
      state_next.mem[0] = state_reg.mem[1];
    end
    if (push)
    begin
      if ((state_reg.count == 2'h0) || (state_reg.count == 2'h1 && pop))
        state_next.mem[0] = i_data;
      else
        state_next.mem[1] = i_data;
    end
    state_next.count = state_reg.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end
endmodule
`default_nettype wire

// File: tb/spi_core_pins_chk.sv
// Concurrent checks on the SPI core pin block
`default_nettype none
module spi_core_pins_chk #(
  parameter int DIV = 4,
  parameter bit WAKE_EN = 1'b0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_master_mode,
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic o_irq,
  input wire logic o_cfg_stby,
  input wire logic o_cfg_wake,
  input wire logic [7:0] o_csn,
  input wire logic o_clk_oe,
  input wire logic o_miso_oe,
  input wire logic o_mosi_oe
);
  // Irq lands 16*DIV+1 cycles after the take; one cycle of slack each way
  localparam int IRQ_LO = 16 * DIV - 8;
  localparam int IRQ_HI = 16 * DIV - 6;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence s_take;
    i_master_mode && i_tx_valid && o_tx_ready;
  endsequence
  sequence s_byte;
    (o_csn != 8'hFF && !o_irq)[*8] ##[IRQ_LO:IRQ_HI] o_irq;
  endsequence
  a_one_select: assert property ($countones(~o_csn) < 2) else $error("select overlap");
  a_byte_frame: assert property (s_take |=> s_byte) else $error("byte frame");
  a_slave_nocs: assert property ((!i_master_mode)[*2] |-> o_csn == 8'hFF) else $error("slave select");
  a_clk_dir: assert property ($stable(i_master_mode)[*2] |-> o_clk_oe == i_master_mode) else $error("clk dir");
  a_miso_dir: assert property (i_master_mode[*2] |-> !o_miso_oe) else $error("miso dir");
  a_mosi_dir: assert property ($stable(i_master_mode)[*2] |-> o_mosi_oe == i_master_mode) else $error("mosi dir");
  a_wake_off: assert property (!WAKE_EN |-> !o_cfg_stby && !o_cfg_wake) else $error("wake on");
  a_irq_pulse: assert property (o_irq |=> !o_irq) else $error("irq width");
endmodule
bind spi_core_pins spi_core_pins_chk #(.DIV(DIV), .WAKE_EN(WAKE_EN)) u_chk (.i_clk_sys, .i_rst, .i_master_mode,
  .i_tx_valid, .o_tx_ready, .o_irq, .o_cfg_stby, .o_cfg_wake, .o_csn, .o_clk_oe, .o_miso_oe, .o_mosi_oe);
`default_nettype wire

// File: tb/spi_far_slave.sv
// Far-side SPI slave: replies with the byte taken in its previous frame
`default_nettype none
module spi_far_slave (
  input wire logic i_sclk,
  input wire logic [7:0] i_csn,
  input wire logic i_mosi,
  output logic o_miso,
  output logic [7:0] o_got
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh_reg = 8'h3C;
  initial o_got = 8'h3C;
  initial o_miso = 1'h0;
  // A released line flips, so a stale bit is never read as good data
  always @(negedge i_sclk or i_csn)
  begin
    if (&i_csn)
    begin
      sh_reg = o_got;
      o_miso = ~o_miso;
    end
    else
    begin
      o_miso = sh_reg[7];
      sh_reg = {sh_reg[6:0], 1'h0};
    end
  end
  always @(posedge i_sclk)
    if (!(&i_csn))
      o_got <= {o_got[6:0], i_mosi};
endmodule
`default_nettype wire

// File: tb/tb_hardened_spi_core_pins.sv
// Bench for the SPI core pin block
`default_nettype none
module tb_hardened_spi_core_pins;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_core_pkg::*;
  logic clk = 1'h0, rst, lclk = 1'h0, mode = 1'h1, tv = 1'h0, rr = 1'h0;
  logic scsn = 1'h1, fsn = 1'h1, smosi = 1'h0, sreq = 1'h1;
  logic tr, rv, irq, stby, wake, cko, coe, mio, mioe, moo, mooe, fmiso;
  logic [7:0] csn, got;
  req_t tq = '0, rw;
  int fail_count = 0, checked = 0;
  wire sclk = coe ? cko : lclk;
  wire mosi = mooe ? moo : smosi;
  always #2.5 clk = ~clk;
  spi_core_pins #(.DIV(2)) u_dut (.i_clk_sys(clk), .i_rst(rst), .i_clk_link(lclk), .i_master_mode(mode),
    .i_tx_valid(tv), .o_tx_ready(tr), .i_tx_req(tq), .o_rx_valid(rv), .i_rx_ready(rr), .o_rx_word(rw),
    .o_irq(irq), .i_stby_req(sreq), .i_wake_req(sreq), .o_cfg_stby(stby), .o_cfg_wake(wake), .o_csn(csn),
    .i_scsn(scsn), .i_user_flash_select_n(fsn), .i_clk_pin(sclk), .o_clk_pin(cko), .o_clk_oe(coe),
    .i_miso(mioe ? mio : fmiso), .o_miso(mio), .o_miso_oe(mioe), .i_mosi(mosi), .o_mosi(moo), .o_mosi_oe(mooe));
  spi_far_slave u_far (.i_sclk(sclk), .i_csn(csn), .i_mosi(mosi), .o_miso(fmiso), .o_got(got));
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wait_irq();
    int n = 0;
    do @(negedge clk); while (irq !== 1'h1 && ++n < 200);
    cmp(irq, 1'h1);
  endtask
  task automatic send(input logic [2:0] idx, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    tq <= '{d, idx, 1'h0};
    tv <= 1'h1;
    do @(negedge clk); while (tr !== 1'h1 && ++n < 200);
    @(posedge clk);
    tv <= 1'h0;
    @(negedge clk);
    cmp(csn, 8'(~(8'h01 << idx)));
    wait_irq();
    cmp(csn, 8'hFF);
    cmp(got, d);
  endtask
  task automatic rx(input logic [7:0] d, input logic fl);
    int n = 0;
    do @(negedge clk); while (rv !== 1'h1 && ++n < 50);
    cmp({rv, rw.data}, {1'h1, d});
    cmp(rw.flash, fl);
    @(posedge clk);
    rr <= 1'h1;
    @(posedge clk);
    rr <= 1'h0;
  endtask
  // Two words fill the buffer and a third waits in the push stage; only then is a request refused
  task automatic stall();
    send(3'h0, 8'h81);
    send(3'h7, 8'h7E);
    send(3'h0, 8'hA5);
    @(posedge clk);
    tv <= 1'h1;
    repeat (4) @(negedge clk);
    cmp(tr, 1'h0);
    @(posedge clk);
    tv <= 1'h0;
    rx(8'h3C, 1'h0);
    rx(8'h81, 1'h0);
    rx(8'h7E, 1'h0);
  endtask
  task automatic selects();
    logic [7:0] prev = 8'hA5;
    for (int i = 1; i < 7; i++)
    begin
      send(3'(i), 8'(i * 17));
      rx(prev, 1'h0);
      prev = 8'(i * 17);
    end
  endtask
  // Link clock gives one more edge after the frame ends; that trailing edge clears the bit count
  task automatic idle();
    #16 lclk = 1'h0;
    scsn <= 1'h1;
    fsn <= 1'h1;
    smosi <= ~smosi;
    #16 lclk = 1'h1;
    #16 lclk = 1'h0;
  endtask
  task automatic frame(input logic [7:0] d, input logic fl, input int bits);
    if (fl)
      fsn <= 1'h0;
    else
      scsn <= 1'h0;
    for (int i = 7; i > 7 - bits; i--)
    begin
      #16 lclk = 1'h0;
      smosi <= d[i];
      #16 lclk = 1'h1;
    end
  endtask
  task automatic slave(input logic [7:0] d, input logic fl);
    frame(d, fl, 8);
    wait_irq();
    cmp({csn, mioe, coe, mio}, {8'hFF, 1'h1, 1'h0, d[7]});
    idle();
    rx(d, fl);
  endtask
  task automatic final_report();
    if (fail_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    rst <= 1'h1;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    idle();
    @(negedge clk);
    cmp({csn, stby, wake, coe}, {8'hFF, 2'h0, 1'h1});
    stall();
    selects();
    @(posedge clk);
    mode <= 1'h0;
    frame(8'hC3, 1'h0, 3);
    idle();
    repeat (10) @(negedge clk);
    cmp(rv, 1'h0);
    slave(8'hA6, 1'h0);
    slave(8'h5B, 1'h1);
    final_report();
  end
  initial
  begin
    #100us;
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
